/* rtl/hspu_consts.vh */
`ifndef HSPU_CONSTS_VH
`define HSPU_CONSTS_VH
`define HSPU_CLK_HZ        32'h00989680
`define HSPU_BAUD_MAX      32'h0000E100
`define HSPU_BAUD_DEF      32'h0000E100
`define HSPU_DIV_MIN       ((`HSPU_CLK_HZ + `HSPU_BAUD_MAX - 32'h00000001) / `HSPU_BAUD_MAX)
`define HSPU_DIV_DEF       (`HSPU_CLK_HZ / `HSPU_BAUD_DEF)
`define HSPU_DATA_BITS     4'h8
`define HSPU_FRAME_BITS    4'hA
`define HSPU_CHAR_LF       8'h0A
`define HSPU_CHAR_CR       8'h0D
`define HSPU_MODE_RS232    2'h1
`define HSPU_MODE_RS485    2'h2
`define HSPU_MODE_BOTH     2'h3
`endif

/* rtl/hspu_uart.v */
`include "hspu_consts.vh"
`default_nettype none
module hspu_uart (
  // Clock and reset.
  input  wire       sys_clk,
  input  wire       rst_n,
  // Channel selection and bit rate divider.
  input  wire [1:0] port_mode,
  input  wire [15:0] baud_div,
  // Transmit user side.
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  input  wire       tx_eol,
  output reg        tx_ready,
  // Receive user side.
  output reg  [7:0] rx_data,
  output reg        rx_valid,
  output reg        rx_eol,
  output reg        rx_frame_err,
  input  wire       rx_room,
  // RS232 pins.
  output reg        rs232_txd,
  output reg        rs232_rts,
  input  wire       rs232_rxd,
  input  wire       rs232_cts,
  // RS485/RS422 four-wire pins.
  output reg        rs485_tx_p,
  output reg        rs485_tx_n,
  input  wire       rs485_rx_p,
  input  wire       rs485_rx_n
);

  ////////////////////////////////////////////////////////////////////////
  localparam [1:0] TX_IDLE = 2'h0;
  localparam [1:0] TX_SEND = 2'h1;
  localparam [1:0] TX_CR   = 2'h2;
  // Dividers are worked out in 32 bits and then cut to the counter width on
  // purpose; both fit easily since the fastest rate needs few clocks.
  localparam [31:0] DIV_MIN_W = `HSPU_DIV_MIN;
  localparam [31:0] DIV_DEF_W = `HSPU_DIV_DEF;
  localparam [15:0] DIV_MIN   = DIV_MIN_W[15:0];
  localparam [15:0] DIV_DEF   = DIV_DEF_W[15:0];

  // Builds one line frame, sent LSB first: start low, eight data, stop high.
  function [9:0] frame_of;
    input [7:0] ch;
    begin
      frame_of = {1'b1, ch, 1'b0};
    end
  endfunction

  // Tells whether a mode code selects a channel; code zero falls back to the
  // single-ended channel so a port left unconfigured still talks to a host.
  function chan_on;
    input [1:0] mode;
    input       diff;
    begin
      if (diff) begin
        chan_on = (mode == `HSPU_MODE_RS485) | (mode == `HSPU_MODE_BOTH);
      end else begin
        chan_on = (mode == `HSPU_MODE_RS232) | (mode == `HSPU_MODE_BOTH) |
                  (mode == 2'h0);
      end
    end
  endfunction

  // A divider below the 57.6k limit is clamped; only a zero divider, which gives 173 clocks, runs faster.
  // A zero divider picks the default rate, so a plain setup needs no number.
  wire [15:0] div_eff = (baud_div == 16'h0000) ? DIV_DEF :
                        (baud_div < DIV_MIN) ? DIV_MIN : baud_div;
  wire use232 = chan_on(port_mode, 1'b0);
  wire use485 = chan_on(port_mode, 1'b1);

  ////////////////////////////////////////////////////////////////////////
  // Transmitter: independent of the receiver, so both run at once.
  // The shifter holds the whole frame and fills with mark from the top, so
  // the line rests high once the stop bit has gone out.
  reg  [1:0]  tx_st_q;
  reg  [9:0]  tx_sh_q;
  reg  [3:0]  tx_cnt_q;
  reg  [15:0] tx_tick_q;
  reg         tx_cr_q;
  wire        cts_ok = ~use232 | ~rs232_cts;
  wire        tx_bit_end = (tx_tick_q == 16'h0001);
  wire        line_bit = tx_sh_q[0];

  // Flow control is checked only between characters so no frame is torn.
  // A host that withdraws permission mid-character still gets all of it.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      tx_st_q   <= TX_IDLE;
      tx_sh_q   <= 10'h3FF;
      tx_cnt_q  <= 4'h0;
      tx_tick_q <= 16'h0000;
      tx_cr_q   <= 1'b0;
      tx_ready  <= 1'b0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          tx_ready <= cts_ok;
          if (tx_ready && tx_valid && cts_ok) begin
            tx_ready  <= 1'b0;
            tx_sh_q   <= frame_of(tx_eol ? `HSPU_CHAR_LF : tx_data);
            tx_cr_q   <= tx_eol;
            tx_cnt_q  <= `HSPU_FRAME_BITS;
            tx_tick_q <= div_eff;
            tx_st_q   <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (tx_bit_end) begin
            tx_tick_q <= div_eff;
            tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
            tx_cnt_q  <= tx_cnt_q - 4'h1;
            if (tx_cnt_q == 4'h1) begin
              tx_st_q <= tx_cr_q ? TX_CR : TX_IDLE;
            end
          end else begin
            tx_tick_q <= tx_tick_q - 16'h0001;
          end
        end
        TX_CR: begin
          // The CR of a line end waits for permission like any character.
          if (cts_ok) begin
            tx_sh_q   <= frame_of(`HSPU_CHAR_CR);
            tx_cr_q   <= 1'b0;
            tx_cnt_q  <= `HSPU_FRAME_BITS;
            tx_tick_q <= div_eff;
            tx_st_q   <= TX_SEND;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // Pin drivers; an unselected channel idles at mark.
  // Registering the pins keeps glitches of the mode decode off the line.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rs232_txd  <= 1'b1;
      rs485_tx_p <= 1'b1;
      rs485_tx_n <= 1'b0;
    end else begin
      rs232_txd  <= use232 ? line_bit : 1'b1;
      rs485_tx_p <= use485 ? line_bit : 1'b1;
      rs485_tx_n <= use485 ? ~line_bit : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receiver: input is the AND of selected channels, each idling high.
  // A channel that is not selected is forced to mark so it never fakes a start.
  reg         rx_s1_q;
  reg         rx_s2_q;
  reg         rx_busy_q;
  reg  [3:0]  rx_cnt_q;
  reg  [15:0] rx_tick_q;
  reg  [8:0]  rx_sh_q;
  wire        rx_raw = (use232 ? rs232_rxd : 1'b1) &
                       (use485 ? (rs485_rx_p & ~rs485_rx_n) : 1'b1);

  // Two stages since the line is asynchronous to sys_clk.
  // Only the second stage is read, so a metastable first stage stays inside.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_raw;
      rx_s2_q <= rx_s1_q;
    end
  end

  // Samples mid-bit; a low stop bit flags a framing error, no parity.
  // The first sample lands half a bit after the edge is seen; a start bit
  // that is high again there is taken as noise and dropped.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      rx_busy_q    <= 1'b0;
      rx_cnt_q     <= 4'h0;
      rx_tick_q    <= 16'h0000;
      rx_sh_q      <= 9'h000;
      rx_data      <= 8'h00;
      rx_valid     <= 1'b0;
      rx_eol       <= 1'b0;
      rx_frame_err <= 1'b0;
      rs232_rts    <= 1'b1;
    end else begin
      rx_valid     <= 1'b0;
      rx_eol       <= 1'b0;
      rx_frame_err <= 1'b0;
      rs232_rts    <= ~rx_room;
      if (!rx_busy_q) begin
        if (!rx_s2_q) begin
          rx_busy_q <= 1'b1;
          rx_cnt_q  <= `HSPU_FRAME_BITS;
          rx_tick_q <= {1'b0, div_eff[15:1]};
        end
      end else if (rx_tick_q == 16'h0000) begin
        rx_tick_q <= div_eff - 16'h0001;
        rx_cnt_q  <= rx_cnt_q - 4'h1;
        rx_sh_q   <= {rx_s2_q, rx_sh_q[8:1]};
        if (rx_cnt_q == `HSPU_FRAME_BITS && rx_s2_q) begin
          rx_busy_q <= 1'b0; // False start.
        end else if (rx_cnt_q == 4'h1) begin
          rx_busy_q <= 1'b0;
          if (rx_s2_q) begin
            rx_data  <= rx_sh_q[8:1];
            rx_valid <= 1'b1;
            rx_eol   <= (rx_sh_q[8:1] == `HSPU_CHAR_CR);
          end else begin
            rx_frame_err <= 1'b1;
          end
        end
      end else begin
        rx_tick_q <= rx_tick_q - 16'h0001;
      end
    end
  end

endmodule // hspu_uart
`default_nettype wire

/* tb/hspu_chk.sv */
`default_nettype none
// Ties the port's outputs to their causes; one clock domain only.
module hspu_chk (
  input wire logic       sys_clk, rst_n, tx_ready, tx_valid, rx_valid, rx_eol, rx_room,
  input wire logic       rs232_txd, rs232_rts, rs232_cts, rs485_tx_p, rs485_tx_n,
  input wire logic [1:0] port_mode,
  input wire logic [7:0] rx_data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  AST_RTS: assert property ($past(rst_n) |-> rs232_rts == !$past(rx_room))
    else $error("rts wrong");
  AST_CTS: assert property ((rs232_cts && port_mode != 2'h2) [*4] |-> !tx_ready)
    else $error("ready under cts");
  AST_TAKE: assert property (tx_ready && tx_valid && !rs232_cts && port_mode != 2'h2
    |=> !tx_ready ##[1:2] !rs232_txd) else $error("no start bit");
  AST_DIFF: assert property (rs485_tx_n == !rs485_tx_p) else $error("pair");
  AST_BOTH: assert property (port_mode == 2'h3 |-> rs485_tx_p == rs232_txd)
    else $error("both");
  AST_MARK232: assert property ($past(port_mode) == 2'h2 |-> rs232_txd)
    else $error("unselected rs232 not at mark");
  AST_MARK485: assert property (!$past(port_mode[1]) |-> rs485_tx_p && !rs485_tx_n)
    else $error("unselected rs485 not at mark");
  AST_PULSE: assert property (rx_valid |=> !rx_valid [*8]) else $error("pulse");
  AST_EOL: assert property (rx_eol |-> rx_valid && rx_data == 8'h0D)
    else $error("eol");
endmodule // hspu_chk
bind hspu_uart hspu_chk chk (.*);
`default_nettype wire

/* tb/hspu_host.sv */
`default_nettype none
// Host terminal: decodes frames and sends its own while RTS allows.
module hspu_host (
  input  wire logic clk, txd, rts,
  output logic      rxd, cts
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BT = 17400; // One bit is 174 clocks of 100 ns.
  logic [7:0] got [$];
  initial {rxd, cts} = 2'h2;
  ////////////////////////////////////////
  // Sampling mid-bit, on a falling edge, so a divider a clock off still reads.
  always begin : rx_p
    logic [7:0] b;
    @(negedge txd);
    #(BT / 2 - 50);
    for (int i = 0; i < 8; i++) #BT b[i] = txd;
    #BT if (txd) got.push_back(b);
  end
  // Sends one frame, LSB first, only once the port grants leave. Permission is
  // looked at on a falling edge, after the port's own edge has updated it.
  task automatic send(input logic [7:0] c, input logic stp = 1'b1);
    logic [9:0] f;
    f = {stp, c, 1'b0};
    do @(negedge clk); while (rts !== 1'b0);
    for (int i = 0; i < 10; i++) begin
      rxd = f[i];
      #BT;
    end
    rxd = 1'b1; // Back to mark, even after a forced low stop bit.
  endtask
endmodule // hspu_host
`default_nettype wire

/* tb/hspu_uart_tb.sv */
`default_nettype none
module hspu_uart_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rst_n, tx_valid, tx_eol, tx_ready, rx_valid, rx_eol, rx_frame_err;
  logic        rx_room, rs232_txd, rs232_rts, rs485_tx_p, rs485_tx_n, h_rxd, h_cts;
  logic [1:0]  port_mode;
  logic [15:0] baud_div;
  logic [7:0]  tx_data, rx_data;
  logic [8:0]  rq [$];
  int          err_count = 0, cmp_count = 0, fe_count = 0;
  hspu_uart dut (.*, .rs232_rxd(h_rxd), .rs232_cts(h_cts), .rs485_rx_p(h_rxd),
    .rs485_rx_n(!h_rxd));
  hspu_host host (.clk(sys_clk), .txd(port_mode == 2'h2 ? rs485_tx_p : rs232_txd),
    .rts(rs232_rts), .rxd(h_rxd), .cts(h_cts));
  ////////////////////////////////////////
  // Received characters, line-end flag on top.
  always @(posedge sys_clk) if (rx_valid === 1'b1) rq.push_back({rx_eol, rx_data});
  // Framing errors; a clean frame must never raise one.
  always @(posedge sys_clk) if (rx_frame_err === 1'b1) fe_count++;
  task automatic chk(input logic [8:0] a, input logic [8:0] e);
    cmp_count++;
    if (a !== e) begin
      err_count++;
      $display("MISMATCH %0t got %h want %h", $time, a, e);
    end
  endtask
  task automatic put(input logic [7:0] c, input logic eol);
    for (int n = 0; n < 9999 && tx_ready !== 1'b1; n++) @(negedge sys_clk);
    chk({8'h00, tx_ready}, 9'h001);
    {tx_data, tx_eol, tx_valid} = {c, eol, 1'b1};
    @(negedge sys_clk);
    {tx_eol, tx_valid} = 2'h0;
  endtask
  task automatic give_verdict;
    $display("mismatches %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Both directions at once per channel choice; 2000 clocks cover one frame.
  task automatic t_duplex;
    logic [15:0] dv [4];
    dv = '{16'h00AE, 16'h0064, 16'h0000, 16'h00AE};
    for (int m = 0; m < 4; m++) begin
      {port_mode, baud_div} = {m[1:0], dv[m]};
      fork host.send(8'h5A + m[7:0]); join_none
      put(8'hA5 - m[7:0], 1'b0);
      repeat (2000) @(negedge sys_clk);
      chk({1'b0, host.got.pop_front()}, 9'h0A5 - m[8:0]);
      chk(rq.pop_front(), 9'h05A + m[8:0]);
    end
  endtask
  // Both ways stall under flow control, then a line end goes each way.
  task automatic t_line;
    {host.cts, rx_room, tx_eol, tx_valid} = 4'hB;
    fork host.send(8'h0D); join_none
    repeat (3000) @(negedge sys_clk);
    chk({1'b0, rs232_rts, 7'(host.got.size() + rq.size())}, 9'h080);
    {host.cts, rx_room} = 2'h1;
    put(8'h00, 1'b1);
    repeat (4000) @(negedge sys_clk);
    chk({1'b0, host.got.pop_front()}, 9'h00A);
    chk({1'b0, host.got.pop_front()}, 9'h00D);
    chk(rq.pop_front(), 9'h10D);
  endtask
  // A low stop bit raises the framing flag once and hands over no character.
  task automatic t_break;
    fork host.send(8'h33, 1'b0); join_none
    repeat (2500) @(negedge sys_clk);
    chk({1'b0, 7'(fe_count), rq.size() == 0}, 9'h003);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // The tests need about 18000 clocks; 30000 means a hang.
  initial begin
    #3000000;
    err_count++;
    give_verdict;
  end
  initial begin
    {rst_n, tx_valid, tx_eol, rx_room, port_mode} = 6'h05;
    {baud_div, tx_data} = 24'h00AE00;
    repeat (20) @(negedge sys_clk);
    chk({rs232_txd, rs485_tx_p, rs485_tx_n, rs232_rts, tx_ready, rx_valid, rx_eol,
      rx_frame_err, 1'b0}, 9'h1A0);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_duplex;
    t_line;
    t_break;
    give_verdict;
  end
endmodule // hspu_uart_tb
`default_nettype wire
